// ### logic/cfmb_defs.svh
`ifndef CFMB_DEFS_SVH
`define CFMB_DEFS_SVH
// ****************************************************************
// register byte addresses
// ****************************************************************
`define CFMB_A_FILT_IDH  12'h000
`define CFMB_A_FILT_IDL  12'h004
`define CFMB_A_FILT_EXH  12'h008
`define CFMB_A_FILT_EXL  12'h00c
`define CFMB_A_MASK_IDH  12'h010
`define CFMB_A_MASK_IDL  12'h014
`define CFMB_A_MASK_EXH  12'h018
`define CFMB_A_MASK_EXL  12'h01c
`define CFMB_A_BT1       12'h020
`define CFMB_A_BT2       12'h024
`define CFMB_A_BT3       12'h028
`define CFMB_A_MODE      12'h02c
`define CFMB_A_STATUS    12'h030
// ****************************************************************
// field positions and values
// ****************************************************************
`define CFMB_EXT_BIT     3
`define CFMB_LOW_WMASK   8'heb
`define CFMB_MLOW_WMASK  8'he3
`define CFMB_BT3_WMASK   8'h47
`define CFMB_PH2SEL_BIT  7
`define CFMB_TRIPLE_BIT  6
`define CFMB_WAKE_BIT    6
`define CFMB_RST_BYTE    8'h00
`define CFMB_WAKE_FLT    4'hf
`define CFMB_IPT_TQ      4'h2
`endif

// ### logic/cfmb_pkg.sv
package cfmb_pkg;
  // acceptance filter with its format select
  typedef struct packed {
    logic [7:0] id_high;
    logic [7:0] id_low;
    logic [7:0] ext_high;
    logic [7:0] ext_low;
  } cfmb_ident_type;
  // decoded bit timing in quanta and oscillator periods
  typedef struct packed {
    logic [7:0] tq_clocks;
    logic [2:0] sjw_tq;
    logic [3:0] prop_tq;
    logic [3:0] ph1_tq;
    logic [3:0] ph2_tq;
    logic [4:0] bit_tq;
    logic       triple;
  } cfmb_timing_type;
  typedef enum logic [1:0] {
    CFMB_ST_SYNC  = 2'b00,
    CFMB_ST_SEG1  = 2'b01,
    CFMB_ST_SEG2  = 2'b11
  } cfmb_seg_type;
endpackage : cfmb_pkg

// ### logic/cfmb_top.sv
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "cfmb_defs.svh"
module cfmb_top
  import cfmb_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic      [31:0] prdata_o,
  output logic             pslverr_o,
  input  wire logic [28:0] rx_id_i,
  input  wire logic        rx_ext_i,
  input  wire logic        rx_bus_i,
  output logic             id_match_o,
  output cfmb_timing_type  timing_o,
  output logic             sample_pulse_o,
  output logic             bit_value_o,
  output logic             wake_o
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    cfmb_ident_type  filt;
    cfmb_ident_type  mask;
    logic [7:0]      bt1;
    logic [7:0]      bt2;
    logic [7:0]      bt3;
    logic            cfg_mode;
    logic            ready;
    logic [31:0]     rdata;
    logic            err;
    logic            match;
    cfmb_timing_type tim;
    logic [1:0]      sync;
    logic [2:0]      samp;
    logic [3:0]      wflt;
    logic            wake;
    logic [7:0]      pre_cnt;
    logic [3:0]      seg_cnt;
    cfmb_seg_type    seg;
    logic            spulse;
    logic            bitv;
  } cfmb_state_type;

  cfmb_state_type st_r;
  cfmb_state_type st_nxt;
  logic [28:0]    fid;
  logic [28:0]    mid;
  logic [3:0]     ph2_auto;
  logic [7:0]     bt_wdata;
  logic           rx_line;

  // identifier bit layout shared by filter and mask
  always_comb begin
    fid = {st_r.filt.id_high, st_r.filt.id_low[7:5], st_r.filt.id_low[1:0],
           st_r.filt.ext_high, st_r.filt.ext_low};
    mid = {st_r.mask.id_high, st_r.mask.id_low[7:5], st_r.mask.id_low[1:0],
           st_r.mask.ext_high, st_r.mask.ext_low};
  end

  assign rx_line  = st_r.sync[1];
  assign bt_wdata = pwdata_i[7:0];
  assign ph2_auto = ({1'b0, st_r.bt2[5:3]} + 4'h1 > `CFMB_IPT_TQ) ?
                    {1'b0, st_r.bt2[5:3]} + 4'h1 : `CFMB_IPT_TQ;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic        acc;
    logic        wr;
    logic [28:0] cmp;
    logic [3:0]  ph2;
    logic [3:0]  seg_end;
    logic [1:0]  votes;
    acc     = psel_i && penable_i && !st_r.ready;
    wr      = acc && pwrite_i;
    cmp     = 29'h0;
    ph2     = 4'h0;
    seg_end = 4'h0;
    votes   = 2'h0;
    st_nxt  = st_r;
    st_nxt.ready  = acc;
    st_nxt.err    = 1'b0;
    st_nxt.rdata  = 32'h0;
    st_nxt.spulse = 1'b0;
    // apb write decode
    if (wr) begin
      if (paddr_i == `CFMB_A_FILT_IDH) begin
        st_nxt.filt.id_high = bt_wdata;
      end else if (paddr_i == `CFMB_A_FILT_IDL) begin
        st_nxt.filt.id_low = bt_wdata & `CFMB_LOW_WMASK;
      end else if (paddr_i == `CFMB_A_FILT_EXH) begin
        st_nxt.filt.ext_high = bt_wdata;
      end else if (paddr_i == `CFMB_A_FILT_EXL) begin
        st_nxt.filt.ext_low = bt_wdata;
      end else if (paddr_i == `CFMB_A_MASK_IDH) begin
        st_nxt.mask.id_high = bt_wdata;
      end else if (paddr_i == `CFMB_A_MASK_IDL) begin
        st_nxt.mask.id_low = bt_wdata & `CFMB_MLOW_WMASK;
      end else if (paddr_i == `CFMB_A_MASK_EXH) begin
        st_nxt.mask.ext_high = bt_wdata;
      end else if (paddr_i == `CFMB_A_MASK_EXL) begin
        st_nxt.mask.ext_low = bt_wdata;
      end else if (paddr_i == `CFMB_A_BT1) begin
        if (st_r.cfg_mode) st_nxt.bt1 = bt_wdata;
        else st_nxt.err = 1'b1;
      end else if (paddr_i == `CFMB_A_BT2) begin
        if (st_r.cfg_mode) st_nxt.bt2 = bt_wdata;
        else st_nxt.err = 1'b1;
      end else if (paddr_i == `CFMB_A_BT3) begin
        if (st_r.cfg_mode) st_nxt.bt3 = bt_wdata & `CFMB_BT3_WMASK;
        else st_nxt.err = 1'b1;
      end else if (paddr_i == `CFMB_A_MODE) begin
        st_nxt.cfg_mode = pwdata_i[0];
      end else if (paddr_i != `CFMB_A_STATUS) begin
        st_nxt.err = 1'b1;
      end else begin
        st_nxt.err = 1'b1;
      end
    end else if (acc) begin
      // apb read decode, narrow data in low bits
      if (paddr_i == `CFMB_A_FILT_IDH) st_nxt.rdata = {24'h0, st_r.filt.id_high};
      else if (paddr_i == `CFMB_A_FILT_IDL) st_nxt.rdata = {24'h0, st_r.filt.id_low};
      else if (paddr_i == `CFMB_A_FILT_EXH) st_nxt.rdata = {24'h0, st_r.filt.ext_high};
      else if (paddr_i == `CFMB_A_FILT_EXL) st_nxt.rdata = {24'h0, st_r.filt.ext_low};
      else if (paddr_i == `CFMB_A_MASK_IDH) st_nxt.rdata = {24'h0, st_r.mask.id_high};
      else if (paddr_i == `CFMB_A_MASK_IDL) st_nxt.rdata = {24'h0, st_r.mask.id_low};
      else if (paddr_i == `CFMB_A_MASK_EXH) st_nxt.rdata = {24'h0, st_r.mask.ext_high};
      else if (paddr_i == `CFMB_A_MASK_EXL) st_nxt.rdata = {24'h0, st_r.mask.ext_low};
      else if (paddr_i == `CFMB_A_BT1) st_nxt.rdata = {24'h0, st_r.bt1};
      else if (paddr_i == `CFMB_A_BT2) st_nxt.rdata = {24'h0, st_r.bt2};
      else if (paddr_i == `CFMB_A_BT3) st_nxt.rdata = {24'h0, st_r.bt3};
      else if (paddr_i == `CFMB_A_MODE) st_nxt.rdata = {31'h0, st_r.cfg_mode};
      else if (paddr_i == `CFMB_A_STATUS) begin
        st_nxt.rdata = {29'h0, st_r.wake, st_r.bitv, st_r.match};
      end else begin
        st_nxt.err = 1'b1;
      end
    end

    // acceptance compare: format must agree, masked bits must equal
    cmp = rx_ext_i ? (rx_id_i ^ fid) & mid
                   : {(rx_id_i[10:0] ^ fid[28:18]) & mid[28:18], 18'h0};
    st_nxt.match = (rx_ext_i == st_r.filt.id_low[`CFMB_EXT_BIT]) && (cmp == 29'h0);

    // decoded timing
    if (st_r.bt2[`CFMB_PH2SEL_BIT]) begin
      ph2 = (st_r.bt3[2:0] == 3'h0) ? 4'h2 : {1'b0, st_r.bt3[2:0]} + 4'h1;
    end else begin
      ph2 = ph2_auto;
    end
    st_nxt.tim.sjw_tq    = {1'b0, st_r.bt1[7:6]} + 3'h1;
    st_nxt.tim.tq_clocks = {1'b0, st_r.bt1[5:0], 1'b0} + 8'h2;
    st_nxt.tim.prop_tq   = {1'b0, st_r.bt2[2:0]} + 4'h1;
    st_nxt.tim.ph1_tq    = {1'b0, st_r.bt2[5:3]} + 4'h1;
    st_nxt.tim.ph2_tq    = ph2;
    st_nxt.tim.bit_tq    = 5'h1 + {1'b0, st_nxt.tim.prop_tq}
                         + {1'b0, st_nxt.tim.ph1_tq} + {1'b0, ph2};
    st_nxt.tim.triple    = st_r.bt2[`CFMB_TRIPLE_BIT];

    // bus line sync and wake-up filter
    st_nxt.sync = {st_r.sync[0], rx_bus_i};
    if (rx_line) st_nxt.wflt = 4'h0;
    else if (st_r.wflt != `CFMB_WAKE_FLT) st_nxt.wflt = st_r.wflt + 4'h1;
    st_nxt.wake = st_r.bt3[`CFMB_WAKE_BIT] ? (st_r.wflt == `CFMB_WAKE_FLT)
                                           : !rx_line;

    // quantum prescaler and segment sequencer
    if (st_r.pre_cnt + 8'h1 >= st_r.tim.tq_clocks) begin
      st_nxt.pre_cnt = 8'h0;
      st_nxt.samp    = {st_r.samp[1:0], rx_line};
      st_nxt.seg_cnt = st_r.seg_cnt + 4'h1;
      case (st_r.seg)
        CFMB_ST_SYNC: begin
          st_nxt.seg     = CFMB_ST_SEG1;
          st_nxt.seg_cnt = 4'h0;
        end
        CFMB_ST_SEG1: begin
          seg_end = st_r.tim.prop_tq + st_r.tim.ph1_tq - 4'h1;
          if (st_r.seg_cnt == seg_end) begin
            st_nxt.seg     = CFMB_ST_SEG2;
            st_nxt.seg_cnt = 4'h0;
            st_nxt.spulse  = 1'b1;
            votes = {1'b0, st_r.samp[0]} + {1'b0, st_r.samp[1]};
            st_nxt.bitv = st_r.tim.triple ? (votes + {1'b0, rx_line} >= 2'h2)
                                          : rx_line;
          end
        end
        default: begin
          if (st_r.seg_cnt == st_r.tim.ph2_tq - 4'h1) begin
            st_nxt.seg     = CFMB_ST_SYNC;
            st_nxt.seg_cnt = 4'h0;
          end
        end
      endcase
    end else begin
      st_nxt.pre_cnt = st_r.pre_cnt + 8'h1;
    end
    if (st_r.cfg_mode) begin
      st_nxt.seg     = CFMB_ST_SYNC;
      st_nxt.pre_cnt = 8'h0;
      st_nxt.seg_cnt = 4'h0;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r          <= '0;
      st_r.cfg_mode <= 1'b1;
      st_r.sync     <= 2'h3;
      st_r.samp     <= 3'h7;
      st_r.bitv     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign pready_o       = st_r.ready;
  assign prdata_o       = st_r.rdata;
  assign pslverr_o      = st_r.err;
  assign id_match_o     = st_r.match;
  assign timing_o       = st_r.tim;
  assign sample_pulse_o = st_r.spulse;
  assign bit_value_o    = st_r.bitv;
  assign wake_o         = st_r.wake;
endmodule : cfmb_top

// ### verif/cfmb_node_model.sv
`timescale 1ns/1ps
// bus node: recessive high unless driving dominant
module cfmb_node_model (
  input  wire logic clock_i,
  input  wire logic dominant_i,
  output logic      rx_bus_o = 1'b1
);
  // line level changes just after the edge
  always @(posedge clock_i) rx_bus_o <= !dominant_i;
endmodule : cfmb_node_model

// ### verif/cfmb_chk.sv
`timescale 1ns/1ps
module cfmb_chk
  import cfmb_pkg::*;
(
  input wire logic            clock_i,
  input wire logic            arst_n_i,
  input wire logic            psel_i,
  input wire logic            penable_i,
  input wire logic            pready_o,
  input wire logic     [31:0] prdata_o,
  input wire logic            pslverr_o,
  input wire cfmb_timing_type timing_o,
  input wire logic            sample_pulse_o
);
  // ****************************************************************
  // bus and timing properties
  // ****************************************************************
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_acc; psel_i && penable_i && !pready_o; endsequence
  sequence s_ans; pready_o ##1 !pready_o; endsequence
  property p_ready; s_acc |=> s_ans; endproperty
  property p_idle; !pready_o |-> prdata_o == 32'h0 && !pslverr_o; endproperty
  property p_upper; pready_o |-> prdata_o[31:8] == 24'h0; endproperty
  property p_sjw; timing_o.bit_tq != 5'h0 |-> timing_o.sjw_tq inside {[1:4]}; endproperty
  property p_tq; timing_o.bit_tq != 5'h0 |-> timing_o.tq_clocks != 8'h0 && !timing_o.tq_clocks[0];
  endproperty
  property p_seg;
    timing_o.bit_tq != 5'h0 |-> timing_o.prop_tq inside {[1:8]} && timing_o.ph1_tq inside {[1:8]};
  endproperty
  property p_ph2; timing_o.bit_tq != 5'h0 |-> timing_o.ph2_tq inside {[2:8]}; endproperty
  property p_bit;
    timing_o.bit_tq != 5'h0 |->
      timing_o.bit_tq == 5'(1 + timing_o.prop_tq + timing_o.ph1_tq + timing_o.ph2_tq);
  endproperty
  property p_pulse; $rose(sample_pulse_o) |=> !sample_pulse_o; endproperty
  a_ready: assert property (p_ready) else $error("ready not a single cycle after access");
  a_idle: assert property (p_idle) else $error("read data or error outside ready");
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  a_sjw: assert property (p_sjw) else $error("jump width out of range");
  a_tq: assert property (p_tq) else $error("quantum not an even count");
  a_seg: assert property (p_seg) else $error("segment length out of range");
  a_ph2: assert property (p_ph2) else $error("phase 2 below two quanta");
  a_bit: assert property (p_bit) else $error("bit time not sum of segments");
  a_pulse: assert property (p_pulse) else $error("sample pulse too long");
endmodule : cfmb_chk
bind cfmb_top cfmb_chk cfmb_chk_inst (.clock_i, .arst_n_i, .psel_i, .penable_i, .pready_o,
  .prdata_o, .pslverr_o, .timing_o, .sample_pulse_o);

// ### verif/tb.sv
`timescale 1ns/1ps
`include "cfmb_defs.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module tb
  import cfmb_pkg::*;
;
  // ****************************************************************
  // stimulus and checks
  // ****************************************************************
  logic clock_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, rx_ext_i = 0;
  logic            dominant = 0;
  logic     [11:0] paddr_i = 0;
  logic     [31:0] pwdata_i = 0;
  logic     [28:0] rx_id_i = 0;
  wire             rx_bus_i, pready_o, pslverr_o, id_match_o, sample_pulse_o, bit_value_o, wake_o;
  wire      [31:0] prdata_o;
  cfmb_timing_type timing_o;
  int              errors = 0, compares = 0;
  // free running clock
  always #2 clock_i = ~clock_i;
  cfmb_top cfmb_top_inst (.clock_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .rx_id_i, .rx_ext_i, .rx_bus_i, .id_match_o,
    .timing_o, .sample_pulse_o, .bit_value_o, .wake_o);
  cfmb_node_model cfmb_node_model_inst (.clock_i, .dominant_i(dominant), .rx_bus_o(rx_bus_i));
  task acc(input logic w, input logic [11:0] a, input logic [7:0] d, e, input logic er);
    int n;
    @(posedge clock_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= {24'h0, d};
    @(posedge clock_i);
    penable_i <= 1;
    n = 0;
    do begin @(posedge clock_i); n++; end while (pready_o !== 1'b1 && n < 20);
    if (!w) `CHK(prdata_o, {24'h0, e})
    `CHK(pslverr_o, er)
    psel_i <= 0;
    penable_i <= 0;
  endtask : acc
  task wr(input logic [11:0] a, input logic [7:0] d); acc(1, a, d, 0, 0); endtask : wr
  task wrd(input logic [11:0] a, input logic [7:0] d, e);
    wr(a, d);
    acc(0, a, 0, e, 0);
  endtask : wrd
  task tchk(input logic [7:0] q, input logic [2:0] s, input logic [3:0] p, h1, h2, input logic t);
    repeat (3) @(posedge clock_i);
    `CHK(timing_o, {q, s, p, h1, h2, 5'(1 + p + h1 + h2), t})
  endtask : tchk
  task mchk(input logic [28:0] id, input logic x, e);
    rx_id_i <= id; rx_ext_i <= x;
    repeat (3) @(posedge clock_i);
    `CHK(id_match_o, e)
  endtask : mchk
  task low(input int n, input logic e);
    dominant <= 1;
    repeat (n) @(posedge clock_i);
    `CHK(wake_o, e)
    dominant <= 0;
    repeat (25) @(posedge clock_i);
  endtask : low
  task t_regs;
    acc(0, `CFMB_A_BT2, 0, 8'h00, 0);
    wrd(`CFMB_A_FILT_IDL, 8'hff, 8'heb);
    wrd(`CFMB_A_MASK_IDL, 8'hff, 8'he3);
    wrd(`CFMB_A_BT3, 8'hff, 8'h47);
  endtask : t_regs
  task t_timing;
    wr(`CFMB_A_BT1, 8'hff); wr(`CFMB_A_BT2, 8'hea); wr(`CFMB_A_BT3, 8'h00);
    tchk(8'h80, 3'd4, 4'd3, 4'd6, 4'd2, 1'b1);
    wr(`CFMB_A_BT3, 8'h05);
    tchk(8'h80, 3'd4, 4'd3, 4'd6, 4'd6, 1'b1);
    wr(`CFMB_A_BT2, 8'h1a);
    tchk(8'h80, 3'd4, 4'd3, 4'd4, 4'd4, 1'b0);
    wr(`CFMB_A_BT1, 8'h00); wr(`CFMB_A_BT2, 8'h02);
    tchk(8'h02, 3'd1, 4'd3, 4'd1, 4'd2, 1'b0);
  endtask : t_timing
  task t_match;
    wr(`CFMB_A_FILT_IDH, 8'h55); wr(`CFMB_A_FILT_IDL, 8'ha0);
    wr(`CFMB_A_MASK_IDH, 8'hff); wr(`CFMB_A_MASK_IDL, 8'he0);
    mchk(29'h2ad, 0, 1);
    mchk(29'h2ac, 0, 0);
    mchk(29'h2ad, 1, 0);
    wr(`CFMB_A_MASK_IDH, 8'h00);
    mchk(29'h0ad, 0, 1);
    wr(`CFMB_A_FILT_IDL, 8'hab); wr(`CFMB_A_FILT_EXH, 8'h12); wr(`CFMB_A_FILT_EXL, 8'h34);
    wr(`CFMB_A_MASK_IDH, 8'hff); wr(`CFMB_A_MASK_IDL, 8'he3);
    wr(`CFMB_A_MASK_EXH, 8'hff); wr(`CFMB_A_MASK_EXL, 8'hff);
    mchk(29'h0ab71234, 1, 1);
    mchk(29'h0ab71235, 1, 0);
    mchk(29'h0ab71234, 0, 0);
  endtask : t_match
  task t_wake;
    wr(`CFMB_A_BT3, 8'h40);
    low(10, 0);
    low(25, 1);
    wr(`CFMB_A_BT3, 8'h00);
    low(10, 1);
  endtask : t_wake
  task t_mode;
    wr(`CFMB_A_MODE, 8'h00);
    acc(1, `CFMB_A_BT1, 8'h3f, 0, 1);
    acc(0, `CFMB_A_BT1, 0, 8'h00, 0);
    acc(0, 12'h100, 0, 8'h00, 1);
    low(40, 1);
    acc(0, `CFMB_A_STATUS, 0, 8'h02, 0);
    t_pulse();
  endtask : t_mode
  // sample point period: 7 quanta of 2 clocks each
  task t_pulse;
    int n;
    n = 0;
    do begin @(posedge clock_i); n++; end while (sample_pulse_o !== 1'b1 && n < 100);
    n = 0;
    do begin @(posedge clock_i); n++; end while (sample_pulse_o !== 1'b1 && n < 100);
    `CHK(n, 14)
  endtask : t_pulse
  task final_report;
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_regs(); t_timing(); t_match(); t_wake(); t_mode();
    final_report();
  end
endmodule : tb
